// ==== core/twi_config_timeout.sv ====
// Configuration register, busy tracking, bus-free and clock-low timeout logic.
`timescale 1ns/1ps
module twi_config_timeout (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CFG_WR,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SCL_OUT_REQ,
    input wire logic SDA_OUT_REQ,
    output logic SCL_OE,
    output logic SDA_OE,
    input wire logic T0_OVF,
    input wire logic T1_OVF,
    input wire logic T2H_OVF,
    input wire logic T2L_OVF,
    input wire logic T3_SPLIT,
    input wire logic START_SEEN,
    input wire logic STOP_SEEN,
    input wire logic SLAVE_IRQ_REQ,
    input wire logic MASTER_IRQ_REQ,
    output logic IRQ,
    output logic BITRATE_TICK,
    output logic SDA_EXTEND,
    output logic T3_RELOAD_HI,
    output logic T3_RELOAD_LO,
    output logic BUS_FREE
);
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic busy_q;
    logic busy_d;
    logic [3:0] free_cnt_q;
    logic [3:0] free_cnt_d;
    logic [1:0] lines;
    logic scl_s;
    logic sda_s;
    logic free_q;

    twi_line_sync #(.WIDTH(twi_cfg_pkg::SYNC_STAGES)) u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .async_in({SCL_IN, SDA_IN}),
        .sync_out(lines)
    );
    assign scl_s = lines[1];
    assign sda_s = lines[0];

    wire enable = cfg_q[twi_cfg_pkg::BIT_ENABLE];
    wire inhibit = cfg_q[twi_cfg_pkg::BIT_INHIBIT];
    wire clk_to_en = cfg_q[twi_cfg_pkg::BIT_CLK_TO];
    wire free_to_en = cfg_q[twi_cfg_pkg::BIT_FREE_TO];
    wire [1:0] src_sel = cfg_q[twi_cfg_pkg::BIT_SRC_HI:twi_cfg_pkg::BIT_SRC_LO];

    // Pick the overflow that paces bit timing.
    wire src_tick = (src_sel == twi_cfg_pkg::SRC_T0) ? T0_OVF :
        (src_sel == twi_cfg_pkg::SRC_T1) ? T1_OVF :
        (src_sel == twi_cfg_pkg::SRC_T2H) ? T2H_OVF : T2L_OVF;

    wire idle_lines = scl_s && sda_s;
    wire free_hit = enable && free_to_en && idle_lines && src_tick
        && (free_cnt_q == 4'(twi_cfg_pkg::FREE_PERIODS));
    assign free_cnt_d = (!enable || !free_to_en || !idle_lines) ? 4'h0 :
        (src_tick && free_cnt_q != 4'(twi_cfg_pkg::FREE_PERIODS)) ?
        free_cnt_q + 4'h1 : free_cnt_q;

    // A start seen in the same cycle as the end of a transfer wins, so busy stays set for
    // the new transfer; a free_hit in that cycle still reaches BUS_FREE two cycles later.
    assign busy_d = !enable ? 1'b0 :
        START_SEEN ? 1'b1 :
        (STOP_SEEN || free_hit) ? 1'b0 : busy_q;

    assign cfg_d = CFG_WR ? (CFG_WDATA & twi_cfg_pkg::CFG_WR_MASK) : cfg_q;

    wire irq_d = enable && (MASTER_IRQ_REQ || (SLAVE_IRQ_REQ && !inhibit));

    wire hold_reload = enable && clk_to_en && scl_s;

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cfg_q <= twi_cfg_pkg::CFG_RESET;
            busy_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            busy_q <= busy_d;
        end
    end

    // The idle counter restarts whenever either line is low, so a short glitch
    // on an otherwise idle bus costs a full new wait rather than a false free.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            free_cnt_q <= 4'h0;
            free_q <= 1'b0;
        end
        else
        begin
            free_cnt_q <= free_cnt_d;
            free_q <= free_hit;
        end
    end

    // Outputs straight from flops; CFG_RDATA is loaded from cfg_d and busy_d so it matches the register, the others lag one cycle.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CFG_RDATA <= 8'h00;
            SDA_EXTEND <= 1'b0;
            BUS_FREE <= 1'b0;
        end
        else
        begin
            CFG_RDATA <= {cfg_d[7:6], busy_d, cfg_d[4:0]};
            SDA_EXTEND <= cfg_q[twi_cfg_pkg::BIT_EXTEND];
            BUS_FREE <= free_q;
        end
    end

    // Pin drives and the interrupt line.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            SCL_OE <= enable && SCL_OUT_REQ;
            SDA_OE <= enable && SDA_OUT_REQ;
            IRQ <= irq_d;
        end
    end

    // Timer controls lag the clock line by three cycles, two of them in the
    // synchroniser; that is negligible against any sensible timeout.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BITRATE_TICK <= 1'b0;
            T3_RELOAD_HI <= 1'b0;
            T3_RELOAD_LO <= 1'b0;
        end
        else
        begin
            BITRATE_TICK <= enable && src_tick;
            T3_RELOAD_HI <= hold_reload;
            T3_RELOAD_LO <= hold_reload && !T3_SPLIT;
        end
    end

    AST_SLAVE_INHIBIT: assert property (@(posedge MCLK) disable iff (!RST_N)
        (inhibit && !MASTER_IRQ_REQ) |=> !IRQ)
        else $error("slave interrupt passed while inhibited");
    AST_MASTER_IRQ: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && MASTER_IRQ_REQ) |=> IRQ)
        else $error("master interrupt lost");
    AST_BUSY_SET: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && START_SEEN) |=> busy_q)
        else $error("busy not set on start");
    AST_BUSY_CLR: assert property (@(posedge MCLK) disable iff (!RST_N)
        (STOP_SEEN && !START_SEEN) |=> !busy_q)
        else $error("busy not cleared on stop");
    AST_EXTEND: assert property (@(posedge MCLK) disable iff (!RST_N)
        ##1 SDA_EXTEND == $past(cfg_q[twi_cfg_pkg::BIT_EXTEND]))
        else $error("extension does not follow config");
    AST_RELOAD_HIGH: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && clk_to_en && scl_s) |=> T3_RELOAD_HI)
        else $error("timer not held while clock high");
    AST_COUNT_LOW: assert property (@(posedge MCLK) disable iff (!RST_N)
        !scl_s |=> !T3_RELOAD_HI && !T3_RELOAD_LO)
        else $error("timer held while clock low");
    AST_SPLIT: assert property (@(posedge MCLK) disable iff (!RST_N)
        T3_SPLIT |=> !T3_RELOAD_LO)
        else $error("low half held in split mode");
    AST_FREE: assert property (@(posedge MCLK) disable iff (!RST_N)
        free_hit |-> free_cnt_q == 4'(twi_cfg_pkg::FREE_PERIODS) && idle_lines)
        else $error("bus free too early");
    AST_DISABLED: assert property (@(posedge MCLK) disable iff (!RST_N)
        !enable |=> !SCL_OE && !SDA_OE && !IRQ)
        else $error("bus driven while disabled");

    // A glitch on either line must throw the idle count away.
    AST_FREE_RESTART: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && !idle_lines) |=> free_cnt_q == 4'h0)
        else $error("idle count kept across a low line");
    AST_FREE_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
        free_hit |-> ##2 BUS_FREE)
        else $error("bus free not reported");
    AST_FREE_BUSY: assert property (@(posedge MCLK) disable iff (!RST_N)
        (free_hit && !START_SEEN) |=> !busy_q)
        else $error("busy not cleared on bus free");

    AST_TICK_SRC: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && src_tick) |=> BITRATE_TICK)
        else $error("selected overflow not passed on");
    AST_SCL_DRIVE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && SCL_OUT_REQ) |=> SCL_OE)
        else $error("clock line not driven when asked");
    AST_SDA_DRIVE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (enable && SDA_OUT_REQ) |=> SDA_OE)
        else $error("data line not driven when asked");

    // Everything towards the timers and the status must rest while switched off.
    AST_TICK_OFF: assert property (@(posedge MCLK) disable iff (!RST_N)
        !enable |=> !BITRATE_TICK && !T3_RELOAD_HI && !T3_RELOAD_LO)
        else $error("timer controls active while disabled");
    AST_BUSY_OFF: assert property (@(posedge MCLK) disable iff (!RST_N)
        !enable |=> !busy_q)
        else $error("busy reported while disabled");

    COV_FREE: cover property (@(posedge MCLK) disable iff (!RST_N) free_hit && busy_q);
    COV_STOP: cover property (@(posedge MCLK) disable iff (!RST_N) busy_q ##1 !busy_q);
    COV_RELOAD: cover property (@(posedge MCLK) disable iff (!RST_N) T3_RELOAD_HI ##1 !T3_RELOAD_HI);
    COV_SPLIT: cover property (@(posedge MCLK) disable iff (!RST_N) T3_SPLIT && T3_RELOAD_HI);
    COV_MASTER_INH: cover property (@(posedge MCLK) disable iff (!RST_N) inhibit ##1 IRQ);
endmodule

// ==== common/twi_cfg_pkg.sv ====
// Constants for the two-wire configuration and timeout block.
package twi_cfg_pkg;
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_INHIBIT = 6;
    localparam int BIT_BUSY = 5;
    localparam int BIT_EXTEND = 4;
    localparam int BIT_CLK_TO = 3;
    localparam int BIT_FREE_TO = 2;
    localparam int BIT_SRC_HI = 1;
    localparam int BIT_SRC_LO = 0;
    localparam logic [7:0] CFG_WR_MASK = 8'hDF;
    localparam logic [1:0] SRC_T0 = 2'h0;
    localparam logic [1:0] SRC_T1 = 2'h1;
    localparam logic [1:0] SRC_T2H = 2'h2;
    localparam logic [1:0] SRC_T2L = 2'h3;
    localparam int FREE_PERIODS = 10;
    localparam int FREE_CNT_W = 4;
    localparam int SYNC_STAGES = 2;
endpackage

// ==== core/twi_line_sync.sv ====
// Two-flop synchroniser for the bus lines.
`timescale 1ns/1ps
module twi_line_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Reset to one: an idle open-drain bus reads high.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ==== test/twi_peer.sv ====
// Bus peer: pull-ups while idle, a 160 ns clock only inside a frame.
`timescale 1ns/1ps
module twi_peer (
    input wire logic go,
    input wire logic stretch,
    output logic scl,
    output logic sda
);
    logic clk_q = 1'b1;
    // A stretching peer holds the clock line low against everyone.
    assign scl = clk_q & ~stretch;
    assign sda = clk_q | ~go;
    always @(posedge go)
    begin
        repeat (18) #80 clk_q = ~clk_q;
    end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the configuration and timeout block.
`timescale 1ns/1ps
module tb_top;
    logic MCLK = 1'b0, RST_N = 1'b0, CFG_WR = 1'b0, T3_SPLIT = 1'b0;
    logic SCL_OUT_REQ = 1'b0, SDA_OUT_REQ = 1'b0, START_SEEN = 1'b0, STOP_SEEN = 1'b0;
    logic SLAVE_IRQ_REQ = 1'b0, MASTER_IRQ_REQ = 1'b0, go = 1'b0, stretch = 1'b0;
    logic [7:0] CFG_WDATA = 8'h00, meas = 8'h00, CFG_RDATA;
    logic [3:0] ovf = 4'h0;
    logic scl, sda, SCL_OE, SDA_OE, IRQ, BITRATE_TICK, SDA_EXTEND;
    logic T3_RELOAD_HI, T3_RELOAD_LO, BUS_FREE;
    int seed = 98, fail_count = 0, comparisons = 0, n, i;
    logic [23:0] exp_q[$], msk_q[$];
    event ev;
    wire [23:0] outs = {meas, CFG_RDATA, SCL_OE, SDA_OE, IRQ, BITRATE_TICK, SDA_EXTEND,
        T3_RELOAD_HI, T3_RELOAD_LO, BUS_FREE};
    always #10 MCLK = ~MCLK;
    twi_peer i_peer (.go(go), .stretch(stretch), .scl(scl), .sda(sda));
    twi_config_timeout i_dut (.MCLK(MCLK), .RST_N(RST_N), .CFG_WR(CFG_WR),
        .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .SCL_IN(scl & ~SCL_OE),
        .SDA_IN(sda & ~SDA_OE), .SCL_OUT_REQ(SCL_OUT_REQ), .SDA_OUT_REQ(SDA_OUT_REQ),
        .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .T0_OVF(ovf[0]), .T1_OVF(ovf[1]),
        .T2H_OVF(ovf[2]), .T2L_OVF(ovf[3]), .T3_SPLIT(T3_SPLIT), .START_SEEN(START_SEEN),
        .STOP_SEEN(STOP_SEEN), .SLAVE_IRQ_REQ(SLAVE_IRQ_REQ), .MASTER_IRQ_REQ(MASTER_IRQ_REQ),
        .IRQ(IRQ), .BITRATE_TICK(BITRATE_TICK), .SDA_EXTEND(SDA_EXTEND),
        .T3_RELOAD_HI(T3_RELOAD_HI), .T3_RELOAD_LO(T3_RELOAD_LO), .BUS_FREE(BUS_FREE));
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        comparisons++;
        if (seen !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // The #1 keeps two notes from landing in one time step and losing an event.
    task automatic note(input logic [23:0] m, input logic [23:0] e);
        msk_q.push_back(m);
        exp_q.push_back(e);
        -> ev;
        #1;
    endtask
    always @(ev)
    begin
        check(outs & msk_q.pop_front(), exp_q.pop_front());
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge MCLK);
    endtask
    task automatic wr(input logic [7:0] d);
        CFG_WR = 1'b1;
        CFG_WDATA = d;
        cyc(1);
        CFG_WR = 1'b0;
        cyc(3);
    endtask
    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        RST_N = 1'b1;
        cyc(2);
        note(24'h00FFFF, 24'h000000);
        n = $random(seed) & 8'h7F;
        wr(n[7:0]);
        {SCL_OUT_REQ, SDA_OUT_REQ, SLAVE_IRQ_REQ, MASTER_IRQ_REQ, go} = 5'h1F;
        // Wait out the whole peer frame so its clock rests high before test 2.
        cyc(80);
        note(24'h00FFE6, {8'h00, n[7:0] & twi_cfg_pkg::CFG_WR_MASK, 8'h00});
        {SCL_OUT_REQ, SDA_OUT_REQ, SLAVE_IRQ_REQ, MASTER_IRQ_REQ, go} = 5'h00;
        $display("test 1 done");
        cyc(40);
        wr(8'h98);
        T3_SPLIT = 1'b1;
        cyc(4);
        note(24'h00000E, 24'h00000C);
        stretch = 1'b1;
        cyc(5);
        note(24'h000006, 24'h000000);
        stretch = 1'b0;
        T3_SPLIT = 1'b0;
        cyc(5);
        note(24'h000006, 24'h000006);
        $display("test 2 done");
        for (i = 0; i < 4; i++)
        begin
            wr(8'h80 | i[7:0]);
            ovf = ~(4'h1 << i);
            cyc(1);
            note(24'h000018, 24'h000000);
            ovf = 4'h1 << i;
            cyc(1);
            note(24'h000018, 24'h000010);
            ovf = 4'h0;
        end
        $display("test 3 done");
        wr(8'hC0);
        {SLAVE_IRQ_REQ, SCL_OUT_REQ, SDA_OUT_REQ} = 3'h7;
        cyc(3);
        note(24'h0000E0, 24'h0000C0);
        MASTER_IRQ_REQ = 1'b1;
        cyc(3);
        note(24'h000020, 24'h000020);
        {SLAVE_IRQ_REQ, SCL_OUT_REQ, SDA_OUT_REQ, MASTER_IRQ_REQ} = 4'h0;
        wr(8'h84);
        START_SEEN = 1'b1;
        cyc(1);
        START_SEEN = 1'b0;
        cyc(2);
        note(24'h002000, 24'h002000);
        STOP_SEEN = 1'b1;
        cyc(1);
        STOP_SEEN = 1'b0;
        cyc(2);
        note(24'h002000, 24'h000000);
        START_SEEN = 1'b1;
        cyc(1);
        START_SEEN = 1'b0;
        for (n = 1; n < 20 && meas == 8'h00; n++)
        begin
            ovf = 4'h1;
            repeat (4)
            begin
                cyc(1);
                ovf = 4'h0;
                if (BUS_FREE === 1'b1)
                    meas = n[7:0];
            end
        end
        note(24'hFF2000, 24'h0B0000);
        $display("test 4 done");
        final_report();
    end
endmodule
